/* hdl/wkg_pkg.sv */
// wkg_pkg: register map, field positions, pattern constants and the
// receive beat carrier for the wake-event and energy-efficient gate.
// assumes a byte-wide register port on the switch core clock.
package wkg_pkg;

  // register offsets
  localparam logic [7:0] REG_SW_STATUS = 8'h7C;
  localparam logic [7:0] REG_SW_MASK = 8'h7D;
  localparam logic [7:0] REG_PORT_STATUS = 8'h80;
  localparam logic [7:0] REG_PORT_MASK = 8'h81;
  localparam logic [7:0] REG_CTRL = 8'h82;

  // switch status / mask fields
  localparam int SW_WAKE_FRAME = 0;
  localparam int SW_LINK_CHG = 1;
  localparam int SW_EEE_CHG = 2;
  localparam int SW_RX_LPI = 3;
  localparam int SW_PME = 4;
  localparam logic [7:0] SW_IRQ_BITS = 8'h0F;
  localparam logic [7:0] SW_PME_BITS = 8'h10;
  localparam logic [7:0] SW_STAT_BITS = 8'h1F;

  // port wake status / mask fields
  localparam int PW_ENERGY = 0;
  localparam int PW_LINK_UP = 1;
  localparam int PW_FRAME = 2;
  localparam logic [7:0] PW_BITS = 8'h07;

  // control fields
  localparam int CTRL_ROUTE_IRQ = 0;
  localparam int CTRL_LOCAL_EEE = 1;
  localparam int CTRL_AN_RESTART = 2;
  localparam int CTRL_TX_LPI_EN = 3;
  localparam int CTRL_RX_LPI_EN = 4;
  localparam logic [7:0] CTRL_BITS = 8'h1B;

  // reset values
  localparam logic [7:0] SW_MASK_RST = 8'h00;
  localparam logic [7:0] PORT_MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h1A;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // wake pattern
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] ADDR_BYTES = 3'h6;
  localparam logic [3:0] LAST_COPY = 4'hF;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;

  localparam int RX_FIFO_DEPTH = 16;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [7:0] data;
  } wkg_beat_t;

  typedef enum logic {WKG_SEEK, WKG_ADDR} wkg_state_t;

endpackage

/* hdl/wkg_top.sv */
// wkg_top: per-port wake-event detector, energy-efficient gate and
// host status/mask registers, with the receive byte FIFO it drains.
// assumes rx beats, negotiation and register strobes on MCLK_I;
// LINK_UP_I and ENERGY_I come from analog pins and are synchronised.
`timescale 1ns/1ps
`default_nettype none

module wkg_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + ONE;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      in_ready_o <= (cnt_next != FULL);
    end
  end
endmodule // wkg_fifo

// How it works
// [R1] eee active only when both ends advertised it in negotiation
// [R2] without eee all low power functions off, tx never requests idle
// [R3] with eee, tx and rx low power idle allowed independently
// [R4] negotiation restarts at reset, on management command, after link loss
// [R5] energy above threshold sets port wake status bit 0
// [R6] link going up sets port wake status bit 1
// [R7] valid wake-pattern frame sets port wake status bit 2
// [R8] frames addressed to node scanned only while port mask bit 2 set
// [R9] pattern needs six all-ones sync bytes first
// [R10] then sixteen unbroken node address copies; any break restarts search
// [R11] sequence accepted at any byte position of the frame
// [R12] broadcast frames also accepted when copies match own address
// [R13] frame without sequence causes no wake action
// [R14] detected pattern drives the wake event output low
// [R15] wake frame routed to interrupt or wake event output by control bit
// [R16] switch mask bits 3:0 gate conditions onto interrupt output
// [R17] switch status bits 3:0 record each occurred condition; bit 3 never sets, since code_d_reg is high whenever lpi_reg is
// [R18] reading switch status clears bits 3:0 that were read
// [R19] switch mask bit 4 gates power wake status onto wake output
// [R20] switch status bit 4 marks power wake event, cleared on read
// [R21] outputs low while any masked status bit pending, else high
// [R22] host reads status after each assertion to clear the cause
// [R23] rx idle indication rises on lpi code start, falls when it ends
module wkg_top
  import wkg_pkg::*;
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // node identity
  input wire logic [47:0] NODE_ADDR_I,
  // receive byte stream
  input wire logic RX_VALID_I,
  input wire wkg_beat_t RX_BEAT_I,
  output logic RX_READY_O,
  // pins
  input wire logic LINK_UP_I,
  input wire logic ENERGY_I,
  // negotiation and lpi signalling
  input wire logic AN_DONE_I,
  input wire logic PARTNER_EEE_ADV_I,
  input wire logic RX_LPI_CODE_I,
  input wire logic TX_LPI_REQ_I,
  output logic AN_RESTART_O,
  output logic EEE_ACTIVE_O,
  output logic TX_LPI_O,
  output logic PARTNER_IDLE_INDICATION_O,
  // host signalling
  output logic HOST_IRQ_OUT_LOW_O,
  output logic WAKE_EVENT_OUT_LOW_O
);

  function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                           input logic [2:0] idx);
    addr_byte = a[8'(47 - 8 * int'(idx)) -: 8];
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // registers
  logic [7:0] sw_st_reg;
  logic [7:0] sw_mask_reg;
  logic [7:0] port_st_reg;
  logic [7:0] port_mask_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] sw_set;
  logic [7:0] port_set;
  logic rd_sw;
  logic rd_port;

  // pin synchronisers
  logic link_s1_reg, link_s2_reg, link_d_reg;
  logic en_s1_reg, en_s2_reg, en_d_reg;
  logic link_rise, link_fall, energy_rise;

  // negotiation / lpi
  logic boot_reg;
  logic eee_en_reg;
  logic eee_d_reg;
  logic code_d_reg;
  logic lpi_reg;
  logic restart_req;

  // rx path
  wkg_beat_t beat;
  logic drain_valid;
  logic drain_ready;
  logic take;
  logic scan_en;
  logic frame_ev;

  // matcher
  wkg_state_t state_reg, state_next;
  logic [2:0] ff_cnt_reg, ff_cnt_next;
  logic [2:0] bi_reg, bi_next;
  logic [3:0] cc_reg, cc_next;
  logic found_reg, found_next;
  logic [2:0] pos_reg, pos_next;
  logic da_node_reg, da_node_next;
  logic da_bc_reg, da_bc_next;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  assign PARTNER_IDLE_INDICATION_O = lpi_reg;
  assign EEE_ACTIVE_O = eee_en_reg;

  // ---------------- pin synchronisers
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      link_s1_reg <= 1'b0;
      link_s2_reg <= 1'b0;
      link_d_reg <= 1'b0;
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      en_d_reg <= 1'b0;
    end else begin
      link_s1_reg <= LINK_UP_I;
      link_s2_reg <= link_s1_reg;
      link_d_reg <= link_s2_reg;
      en_s1_reg <= ENERGY_I;
      en_s2_reg <= en_s1_reg;
      en_d_reg <= en_s2_reg;
    end
  end

  assign link_rise = link_s2_reg && !link_d_reg;
  assign link_fall = !link_s2_reg && link_d_reg;
  assign energy_rise = en_s2_reg && !en_d_reg;

  // ---------------- negotiation and eee gate
  assign restart_req = boot_reg || link_fall ||
                       (REG_WR_I && hit(REG_ADDR_I, REG_CTRL) &&
                        REG_WDATA_I[CTRL_AN_RESTART]);

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      boot_reg <= 1'b1;
      AN_RESTART_O <= 1'b0;
      eee_en_reg <= 1'b0;
      eee_d_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b0;
      AN_RESTART_O <= restart_req; // R4
      eee_d_reg <= eee_en_reg;
      if (restart_req || !link_s2_reg) begin
        eee_en_reg <= 1'b0; // R4
      end else if (AN_DONE_I) begin
        eee_en_reg <= ctrl_reg[CTRL_LOCAL_EEE] && PARTNER_EEE_ADV_I; // R1
      end
    end
  end

  // independent tx and rx idle gating
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      TX_LPI_O <= 1'b0;
    end else begin
      TX_LPI_O <= eee_en_reg && ctrl_reg[CTRL_TX_LPI_EN] && TX_LPI_REQ_I; // R2 R3
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      code_d_reg <= 1'b0;
      lpi_reg <= 1'b0;
    end else begin
      code_d_reg <= RX_LPI_CODE_I;
      if (!RX_LPI_CODE_I || !eee_en_reg || !ctrl_reg[CTRL_RX_LPI_EN]) begin
        lpi_reg <= 1'b0; // R23 R2
      end else if (!code_d_reg) begin
        lpi_reg <= 1'b1; // R23 R3
      end
    end
  end

  // ---------------- receive buffer; drain stalls while partner idles
  wkg_fifo #(
    .W($bits(wkg_beat_t)),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(RX_VALID_I),
    .in_data_i(RX_BEAT_I),
    .in_ready_o(RX_READY_O),
    .out_valid_o(drain_valid),
    .out_data_o(beat),
    .out_ready_i(drain_ready)
  );

  assign drain_ready = !lpi_reg;
  assign take = drain_valid && drain_ready;
  assign scan_en = port_mask_reg[PW_FRAME]; // R8

  // ---------------- pattern matcher
  always_comb begin
    state_next = beat.sof ? WKG_SEEK : state_reg; // R11
    ff_cnt_next = beat.sof ? '0 : ff_cnt_reg;
    bi_next = beat.sof ? '0 : bi_reg;
    cc_next = beat.sof ? '0 : cc_reg;
    found_next = beat.sof ? 1'b0 : found_reg;
    pos_next = beat.sof ? '0 : pos_reg;
    da_node_next = beat.sof ? 1'b1 : da_node_reg;
    da_bc_next = beat.sof ? 1'b1 : da_bc_reg;
    // destination check over the first address-length bytes
    if (pos_next != ADDR_BYTES) begin
      da_node_next = da_node_next &&
                     (beat.data == addr_byte(NODE_ADDR_I, pos_next)); // R8
      da_bc_next = da_bc_next &&
                   (beat.data == addr_byte(BCAST_ADDR, pos_next)); // R12
      pos_next = pos_next + 3'h1;
    end
    case (state_next)
      WKG_SEEK: begin
        if (beat.data == SYNC_BYTE) begin
          if (ff_cnt_next != SYNC_LEN) begin
            ff_cnt_next = ff_cnt_next + 3'h1; // R9
          end
        end else if (ff_cnt_next == SYNC_LEN &&
                     beat.data == addr_byte(NODE_ADDR_I, 3'h0)) begin
          state_next = WKG_ADDR; // R9
          bi_next = 3'h1;
          cc_next = '0;
          ff_cnt_next = '0;
        end else begin
          ff_cnt_next = '0;
        end
      end
      WKG_ADDR: begin
        if (beat.data == addr_byte(NODE_ADDR_I, bi_next)) begin
          if (bi_next == ADDR_BYTES - 3'h1) begin
            bi_next = '0;
            if (cc_next == LAST_COPY) begin
              found_next = 1'b1; // R10
              state_next = WKG_SEEK;
            end else begin
              cc_next = cc_next + 4'h1;
            end
          end else begin
            bi_next = bi_next + 3'h1;
          end
        end else begin
          state_next = WKG_SEEK; // R10
          bi_next = '0;
          cc_next = '0;
          ff_cnt_next = (beat.data == SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end
      default: begin
        state_next = WKG_SEEK;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !scan_en) begin
      state_reg <= WKG_SEEK;
      ff_cnt_reg <= '0;
      bi_reg <= '0;
      cc_reg <= '0;
      found_reg <= 1'b0;
      pos_reg <= '0;
      da_node_reg <= 1'b0;
      da_bc_reg <= 1'b0;
    end else if (take) begin
      state_reg <= state_next;
      ff_cnt_reg <= ff_cnt_next;
      bi_reg <= bi_next;
      cc_reg <= cc_next;
      found_reg <= found_next;
      pos_reg <= pos_next;
      da_node_reg <= da_node_next;
      da_bc_reg <= da_bc_next;
    end
  end

  // one pulse at end of a qualifying frame; otherwise nothing
  assign frame_ev = take && scan_en && beat.eof && found_next &&
                    (da_node_next || da_bc_next); // R12 R13

  // ---------------- status and mask registers
  assign rd_sw = REG_RD_I && hit(REG_ADDR_I, REG_SW_STATUS);
  assign rd_port = REG_RD_I && hit(REG_ADDR_I, REG_PORT_STATUS);

  always_comb begin
    port_set = ZERO_BYTE;
    port_set[PW_ENERGY] = energy_rise; // R5
    port_set[PW_LINK_UP] = link_rise; // R6
    port_set[PW_FRAME] = frame_ev; // R7
    sw_set = ZERO_BYTE;
    sw_set[SW_WAKE_FRAME] = frame_ev && ctrl_reg[CTRL_ROUTE_IRQ]; // R15
    sw_set[SW_LINK_CHG] = link_rise || link_fall; // R17
    sw_set[SW_EEE_CHG] = eee_en_reg ^ eee_d_reg; // R17
    sw_set[SW_RX_LPI] = lpi_reg && !code_d_reg; // R17
    sw_set[SW_PME] = |(port_set[PW_LINK_UP:PW_ENERGY] &
                       port_mask_reg[PW_LINK_UP:PW_ENERGY]) ||
                     (frame_ev && !ctrl_reg[CTRL_ROUTE_IRQ]); // R14 R15 R20
  end

  // a set in the cycle of the clearing read survives
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      sw_st_reg <= ZERO_BYTE;
      port_st_reg <= ZERO_BYTE;
    end else begin
      sw_st_reg <= ((sw_st_reg & ~({8{rd_sw}} & SW_STAT_BITS)) | sw_set)
                   & SW_STAT_BITS; // R17 R18 R20
      port_st_reg <= ((port_st_reg & ~({8{rd_port}} & PW_BITS)) | port_set)
                     & PW_BITS;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      sw_mask_reg <= SW_MASK_RST;
      port_mask_reg <= PORT_MASK_RST;
      ctrl_reg <= CTRL_RST;
    end else if (REG_WR_I) begin
      if (hit(REG_ADDR_I, REG_SW_MASK)) begin
        sw_mask_reg <= REG_WDATA_I & SW_STAT_BITS;
      end
      if (hit(REG_ADDR_I, REG_PORT_MASK)) begin
        port_mask_reg <= REG_WDATA_I & PW_BITS;
      end
      if (hit(REG_ADDR_I, REG_CTRL)) begin
        ctrl_reg <= REG_WDATA_I & CTRL_BITS;
      end
    end
  end

  // read answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= ZERO_BYTE;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          REG_SW_STATUS: REG_RDATA_O <= sw_st_reg;
          REG_SW_MASK: REG_RDATA_O <= sw_mask_reg;
          REG_PORT_STATUS: REG_RDATA_O <= port_st_reg;
          REG_PORT_MASK: REG_RDATA_O <= port_mask_reg;
          REG_CTRL: REG_RDATA_O <= ctrl_reg;
          default: REG_RDATA_O <= ZERO_BYTE;
        endcase
      end
    end
  end

  // output lines follow pending masked status; host read releases them
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      HOST_IRQ_OUT_LOW_O <= 1'b1;
      WAKE_EVENT_OUT_LOW_O <= 1'b1;
    end else begin
      HOST_IRQ_OUT_LOW_O <= !(|(sw_st_reg & sw_mask_reg & SW_IRQ_BITS)); // R16 R21 R22
      WAKE_EVENT_OUT_LOW_O <= !(|(sw_st_reg & sw_mask_reg & SW_PME_BITS)); // R19 R21
    end
  end

  // ---------------- checks

  AST_EEE_NEEDS_BOTH: assert property ( // R1
    $rose(eee_en_reg) |-> $past(AN_DONE_I && PARTNER_EEE_ADV_I))
    else $error("eee enabled without both advertisements");

  AST_NO_TX_LPI_WITHOUT_EEE: assert property ( // R2
    TX_LPI_O |-> $past(eee_en_reg && TX_LPI_REQ_I))
    else $error("tx idle requested while eee off");

  AST_RESTART_ON_LINK_FAIL: assert property ( // R4
    link_fall |=> AN_RESTART_O && !eee_en_reg)
    else $error("link loss did not restart negotiation");

  AST_ENERGY_SETS: assert property ( // R5
    energy_rise |=> port_st_reg[PW_ENERGY])
    else $error("energy event not recorded");

  AST_LINK_SETS: assert property ( // R6
    link_rise |=> port_st_reg[PW_LINK_UP])
    else $error("link up not recorded");

  AST_FRAME_SETS: assert property ( // R7
    frame_ev |=> port_st_reg[PW_FRAME] ##1 !WAKE_EVENT_OUT_LOW_O ||
                 !sw_mask_reg[SW_PME] || ctrl_reg[CTRL_ROUTE_IRQ])
    else $error("wake frame not recorded or not signalled");

  AST_NO_SCAN_MASKED: assert property ( // R8
    (!port_mask_reg[PW_FRAME] && !port_st_reg[PW_FRAME])
    |=> !port_st_reg[PW_FRAME])
    else $error("frame scanned while masked");

  AST_READ_CLEARS: assert property ( // R18
    (rd_sw && sw_set == ZERO_BYTE) |=> sw_st_reg == ZERO_BYTE)
    else $error("status read did not clear");

  AST_IRQ_LEVEL: assert property ( // R21
    (|(sw_st_reg & sw_mask_reg & SW_IRQ_BITS)) |=> !HOST_IRQ_OUT_LOW_O)
    else $error("interrupt line not low while pending");

  AST_RX_IDLE: assert property ( // R23
    $rose(lpi_reg) |-> $past(RX_LPI_CODE_I) && !$past(code_d_reg))
    else $error("idle indication without lpi code start");

endmodule // wkg_top

`default_nettype wire

/* tb/wake_event_and_eee_gate_test.sv */
// wake_event_and_eee_gate_test: self-checking bench for wkg_top.
// assumes wkg_link_partner as rx source; bench acts as host.
`timescale 1ns/1ps
`default_nettype none
module wake_event_and_eee_gate_test
  import wkg_pkg::*;
;
  localparam logic [47:0] NODE = 48'h0A1B_2C3D_4E5F;
  logic clk = 1'h0, rst = 1'h1, wr_stb = 1'h0, rd_stb = 1'h0;
  logic [7:0] ra = 8'h00, wd = 8'h00, rdata, d;
  logic rvalid, rxv, rxr, an_rst, eee, tx_lpi, idle, irq_n, wake_n;
  logic link = 1'h0, energy = 1'h0, an_done = 1'h0, adv = 1'h0;
  logic lpi_code = 1'h0, lpi_req = 1'h0;
  wkg_beat_t beat;
  int n_mismatch = 0, compares = 0, n_acc = 0, base;
  logic [7:0] fq[$];
  logic [7:0] ra_t[4] = '{REG_SW_MASK, REG_PORT_MASK, REG_CTRL, 8'h55};
  logic [7:0] rv_t[4] = '{SW_MASK_RST, PORT_MASK_RST, CTRL_RST, ZERO_BYTE};
  logic [47:0] da_t[5] = '{NODE, NODE, BCAST_ADDR, 48'h0202_0202_0202, NODE};
  int cp_t[5] = '{16, 15, 16, 16, 16};

  always #20 clk = ~clk;
  always @(posedge clk) if (rxv && rxr) n_acc <= n_acc + 1;

  wkg_top DUT (.MCLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(ra),
    .REG_WR_I(wr_stb), .REG_RD_I(rd_stb), .REG_WDATA_I(wd),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .NODE_ADDR_I(NODE),
    .RX_VALID_I(rxv), .RX_BEAT_I(beat), .RX_READY_O(rxr),
    .LINK_UP_I(link), .ENERGY_I(energy), .AN_DONE_I(an_done),
    .PARTNER_EEE_ADV_I(adv), .RX_LPI_CODE_I(lpi_code),
    .TX_LPI_REQ_I(lpi_req), .AN_RESTART_O(an_rst), .EEE_ACTIVE_O(eee),
    .TX_LPI_O(tx_lpi), .PARTNER_IDLE_INDICATION_O(idle),
    .HOST_IRQ_OUT_LOW_O(irq_n), .WAKE_EVENT_OUT_LOW_O(wake_n));

  wkg_link_partner LP (.clk_i(clk), .ready_i(rxr), .valid_o(rxv),
    .beat_o(beat));

  task automatic stop_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      n_mismatch++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return wake_n;
      1: return irq_n;
      2: return rxr;
      default: return an_rst;
    endcase
  endfunction

  // bounded wait for one output to reach a level
  task automatic wfor(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (pick(k) !== v) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    ra <= a;
    wd <= v;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    ra <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    @(posedge clk);
    chk(rvalid, 1'h1);
    v = rdata;
  endtask

  // frame: da, random sa and junk, sync bytes, address copies, trailer
  task automatic mk(input logic [47:0] da, input int copies);
    int nj;
    fq = {};
    nj = $urandom_range(7);
    for (int i = 0; i < 12 + nj; i++)
      fq.push_back(i < 6 ? da[47 - 8 * i -: 8] : 8'($urandom_range(126)));
    for (int i = 0; i < 6; i++) fq.push_back(SYNC_BYTE);
    for (int i = 0; i < 6 * copies; i++)
      fq.push_back(NODE[47 - 8 * (i % 6) -: 8]);
    fq.push_back(8'h00);
  endtask

  // reference scan: addressed to node or broadcast, pattern anywhere
  function automatic logic scan(input logic [7:0] q[$]);
    logic [47:0] da;
    logic hit;
    da = '0;
    hit = 1'h0;
    for (int i = 0; i < 6; i++) da = {da[39:0], q[i]};
    for (int p = 0; p + 102 <= q.size(); p++) begin
      logic ok;
      ok = 1'h1;
      for (int j = 0; j < 102; j++)
        if (q[p + j] !== (j < 6 ? SYNC_BYTE : NODE[47 - 8 * ((j - 6) % 6) -: 8]))
          ok = 1'h0;
      hit = hit | ok;
    end
    return hit && (da == NODE || da == BCAST_ADDR);
  endfunction

  task automatic check_frame(input logic exp);
    if (exp) wfor(0, 1'h0, 80);
    else wt(40);
    chk(wake_n, !exp);
    rd(REG_PORT_STATUS, d);
    chk(d & 8'h04, {5'h0, exp, 2'h0});
    rd(REG_SW_STATUS, d);
    chk(d & 8'h10, {3'h0, exp, 4'h0});
    wt(3);
    chk(wake_n, 1'h1);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    void'($urandom(88));
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    wfor(3, 1'h1, 4);
    chk(an_rst, 1'h1);
    for (int i = 0; i < 4; i++) begin
      rd(ra_t[i], d);
      chk(d, rv_t[i]);
    end
    link <= 1'h1;
    wt(8);
    rd(REG_PORT_STATUS, d);
    chk(d & PW_BITS, 8'h02);
    energy <= 1'h1;
    wt(8);
    rd(REG_PORT_STATUS, d);
    chk(d & PW_BITS, 8'h01);
    link <= 1'h0;
    wfor(3, 1'h1, 8);
    chk(an_rst, 1'h1);
    link <= 1'h1;
    wt(8);
    rd(REG_PORT_STATUS, d);
    rd(REG_SW_STATUS, d);
    // negotiation outcome against partner advertisement and the tx idle enable
    for (int c = 0; c < 4; c++) begin
      wr(REG_CTRL, {3'h0, 1'h1, c[1], 3'h2});
      adv <= c[0];
      an_done <= 1'h1;
      @(posedge clk);
      an_done <= 1'h0;
      lpi_req <= 1'h1;
      lpi_code <= 1'h1;
      wt(4);
      chk(eee, c[0]);
      chk(tx_lpi, c[0] & c[1]);
      chk(idle, c[0]);
      lpi_req <= 1'h0;
      lpi_code <= 1'h0;
      wt(3);
      chk(idle, 1'h0);
    end
    // management restart drops eee until renegotiated
    wr(REG_CTRL, CTRL_RST | 8'h04);
    wfor(3, 1'h1, 4);
    chk(an_rst, 1'h1);
    chk(eee, 1'h0);
    an_done <= 1'h1;
    @(posedge clk);
    an_done <= 1'h0;
    // fifo fills while rx idle stalls the drain
    wr(REG_PORT_MASK, 8'h04);
    wr(REG_SW_MASK, 8'h10);
    mk(NODE, 16);
    lpi_code <= 1'h1;
    wt(4);
    base = n_acc;
    fork
      LP.send_frame(fq, 0);
    join_none
    wfor(2, 1'h0, 100);
    wt(2);
    chk(8'(n_acc - base), 8'(RX_FIFO_DEPTH));
    lpi_code <= 1'h0;
    wait fork;
    check_frame(1'h1);
    for (int i = 0; i < 5; i++) begin
      mk(da_t[i], cp_t[i]);
      wr(REG_PORT_MASK, i != 4 ? 8'h04 : 8'h00);
      LP.send_frame(fq, 30);
      check_frame(i != 4 && scan(fq));
    end
    // wake frame routed to the interrupt line
    wr(REG_CTRL, 8'h1B);
    wr(REG_SW_MASK, 8'h01);
    wr(REG_PORT_MASK, 8'h04);
    mk(NODE, 16);
    LP.send_frame(fq, 30);
    wfor(1, 1'h0, 80);
    chk(wake_n, 1'h1);
    rd(REG_SW_STATUS, d);
    chk(d & 8'h11, 8'h01);
    rd(REG_PORT_STATUS, d);
    chk(d & 8'h04, 8'h04);
    wt(3);
    chk(irq_n, 1'h1);
    chk(8'(LP.hung), 8'h00);
    stop_test();
  end
endmodule // wake_event_and_eee_gate_test
`default_nettype wire

/* tb/wkg_link_partner.sv */
// wkg_link_partner: receive-side link partner streaming frame bytes.
// assumes send_frame is called just after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module wkg_link_partner
  import wkg_pkg::*;
(
  // clock
  input wire logic clk_i,
  // byte stream
  input wire logic ready_i,
  output logic valid_o,
  output wkg_beat_t beat_o
);
  int hung = 0;
  initial begin
    valid_o = 1'h0;
    beat_o = '0;
  end
  // byte held until taken; data toggles while idle
  task automatic send_frame(input logic [7:0] q[$], input int stall);
    int n;
    for (int i = 0; i < q.size(); i++) begin
      while ($urandom_range(99) < stall) begin
        valid_o <= 1'h0;
        beat_o.data <= ~beat_o.data;
        @(posedge clk_i);
      end
      valid_o <= 1'h1;
      beat_o <= '{sof: i == 0, eof: i == q.size() - 1, data: q[i]};
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (!ready_i && n < 1000);
      if (n >= 1000) hung++;
    end
    valid_o <= 1'h0;
    beat_o.data <= ~beat_o.data;
  endtask
endmodule // wkg_link_partner
`default_nettype wire
